// ### hw/pds_defines.vh
// Register offsets, field positions, code values and reset values of the discovery and power status bank.
`ifndef PDS_DEFINES_VH
`define PDS_DEFINES_VH
`define PDS_ADDR_CH3_DISC  8'h0E
`define PDS_ADDR_CH4_DISC  8'h0F
`define PDS_ADDR_PWR_STATE 8'h10
`define PDS_RESET_BYTE     8'h00
`define PDS_CLS_MSB        7
`define PDS_CLS_LSB        4
`define PDS_DET_MSB        3
`define PDS_DET_LSB        0
`define PDS_PG_LSB         4
`define PDS_PE_LSB         0
`define PDS_CLS_UNKNOWN    4'h0
`define PDS_CLS_RSVD5      4'h5
`define PDS_CLS_ZERO       4'h6
`define PDS_CLS_T1_LIMITED 4'hC
`define PDS_CLS_RSVD14     4'hE
`define PDS_CLS_MISMATCH   4'hF
`define PDS_DET_UNKNOWN    4'h0
`define PDS_DET_RSVD2      4'h2
`define PDS_DET_RSVD7      4'h7
`define PDS_DET_MOS_FAULT  4'hE
`define PDS_ASSIGN_CLS0_AS 3'h3
`define PDS_ALLOC_LOWEST   3'h0
`define PDS_MIN_T1_CLASS   4'h4
`endif

// ### hw/pds_class_map.v
// Maps the requested class result of one channel onto its reported code and assigned class.
`include "pds_defines.vh"

module pds_class_map (
  input  wire [3:0] cls_raw_i,
  input  wire [3:0] det_raw_i,
  input  wire [2:0] alloc_i,
  output reg  [3:0] cls_code_o,
  output reg  [3:0] det_code_o,
  output reg  [2:0] assigned_o
);

  // Filters the class code: reserved 5 reads as class zero, 14 as unknown; lowest allocation forces type-1 limited for class four and up.
  always @* begin
    cls_code_o = cls_raw_i;
    if (cls_raw_i == `PDS_CLS_RSVD5) begin
      cls_code_o = `PDS_CLS_ZERO;
    end else if (cls_raw_i == `PDS_CLS_RSVD14) begin
      cls_code_o = `PDS_CLS_UNKNOWN;
    end
    if (alloc_i == `PDS_ALLOC_LOWEST && cls_raw_i >= `PDS_MIN_T1_CLASS && cls_raw_i != `PDS_CLS_ZERO &&
        cls_raw_i != 4'h7 && cls_raw_i != `PDS_CLS_MISMATCH && cls_raw_i != `PDS_CLS_RSVD5 &&
        cls_raw_i != `PDS_CLS_RSVD14) begin
      cls_code_o = `PDS_CLS_T1_LIMITED;
    end
  end

  // Filters the detection code: reserved codes read as unknown.
  always @* begin
    det_code_o = det_raw_i;
    if (det_raw_i == `PDS_DET_RSVD2 || det_raw_i == `PDS_DET_RSVD7 ||
        (det_raw_i > `PDS_DET_RSVD7 && det_raw_i != `PDS_DET_MOS_FAULT)) begin
      det_code_o = `PDS_DET_UNKNOWN;
    end
  end

  // Assigned class follows the allocation, except a class zero load is given class three.
  always @* begin
    assigned_o = alloc_i;
    if (cls_raw_i == `PDS_CLS_ZERO || cls_raw_i == `PDS_CLS_RSVD5) begin
      assigned_o = `PDS_ASSIGN_CLS0_AS;
    end
  end

endmodule

// ### hw/pds_status_bank.v
// Discovery (channels three and four) and power status (channels one to four) register bank of the power sourcing controller.
//
// How it works
// - Channel 3 discovery reads at 0x0E, channel 4 at 0x0F, one byte each.
// - Discovery byte: requested class in upper nibble, detection in lower nibble.
// - A channel turning off clears its discovery byte to zero.
// - Class codes: 0 unknown, 1-4 classes, 5 reads as class zero, 6 zero.
// - Codes 8-11 are single-signature classes 5-8; 13 is dual-signature class 5.
// - Code 7 overcurrent, 12 type-1 limited, 14 reserved, 15 mismatch.
// - Requested class is the class measured before turn-on.
// - Assigned class is the powered level taken from the allocation setting.
// - Class four or higher at lowest allocation reports the type-1 limited code.
// - A powered class zero load gets assigned class three.
// - Power state at 0x10: power-good in bits 7-4, enabled in bits 3-0.
// - Power-good is one only when on and drain fell below threshold during turn-on.
// - Power-good latches after turn-on; clears only on turn-off or reset.
// - Enabled flag reads one while the channel is on.
// - Turn-off, fault or not, clears both power flags of the channel.
// - Four-pair dual-signature ports update each channel's power flags individually.
// - Four-pair single signature sets power-good only after both channels changed.
// - Four-pair dual signature raises change events per channel.
// - A power flag falling from one to zero raises its change event.
`include "pds_defines.vh"

module pds_status_bank #(
  parameter NCH = 4
) (
  input  wire           clk_i,
  input  wire           resetn_i,
  input  wire [NCH-1:0] ch_on_i,
  input  wire [NCH-1:0] drain_sense_pin_i,
  input  wire [NCH-1:0] turn_on_done_i,
  input  wire [1:0]     four_pair_i,
  input  wire [1:0]     dual_sig_i,
  input  wire [3:0]     ch3_cls_i,
  input  wire [3:0]     ch3_det_i,
  input  wire           ch3_disc_valid_i,
  input  wire [3:0]     ch4_cls_i,
  input  wire [3:0]     ch4_det_i,
  input  wire           ch4_disc_valid_i,
  input  wire [2:0]     alloc_ch3_i,
  input  wire [2:0]     alloc_ch4_i,
  input  wire           reg_rd_i,
  input  wire           reg_wr_i,
  input  wire [7:0]     reg_addr_i,
  input  wire [7:0]     reg_wdata_i,
  output reg  [7:0]     reg_rdata_o,
  output reg            reg_rvalid_o,
  output reg  [2:0]     ch3_assigned_o,
  output reg  [2:0]     ch4_assigned_o,
  output reg  [NCH-1:0] power_good_change_event_o,
  output reg  [NCH-1:0] power_enable_change_event_o
);

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  reg  [7:0]     ch3_disc_q;
  reg  [7:0]     ch4_disc_q;
  reg  [NCH-1:0] power_good_flags_q;
  reg  [NCH-1:0] power_enabled_flags_q;
  reg  [NCH-1:0] pg_raw_q;
  reg  [NCH-1:0] pg_seen_q;
  reg  [NCH-1:0] pg_d;
  reg  [NCH-1:0] pg_raw_d;
  reg  [NCH-1:0] pg_seen_d;
  wire [3:0]     ch3_cls_code;
  wire [3:0]     ch3_det_code;
  wire [2:0]     ch3_assigned;
  wire [3:0]     ch4_cls_code;
  wire [3:0]     ch4_det_code;
  wire [2:0]     ch4_assigned;
  integer        i;
  integer        p;

  // ---------------------------------------------------------------
  // Class mapping for channels three and four
  // ---------------------------------------------------------------
  pds_class_map u_map3 (
    .cls_raw_i  (ch3_cls_i),
    .det_raw_i  (ch3_det_i),
    .alloc_i    (alloc_ch3_i),
    .cls_code_o (ch3_cls_code),
    .det_code_o (ch3_det_code),
    .assigned_o (ch3_assigned)
  );

  pds_class_map u_map4 (
    .cls_raw_i  (ch4_cls_i),
    .det_raw_i  (ch4_det_i),
    .alloc_i    (alloc_ch4_i),
    .cls_code_o (ch4_cls_code),
    .det_code_o (ch4_det_code),
    .assigned_o (ch4_assigned)
  );

  // ---------------------------------------------------------------
  // Discovery registers
  // ---------------------------------------------------------------
  // A new result is captured before turn-on; turn-off wins over a capture in the same cycle.
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      ch3_disc_q <= `PDS_RESET_BYTE;
      ch4_disc_q <= `PDS_RESET_BYTE;
    end else begin
      if (!ch_on_i[2] && power_enabled_flags_q[2]) begin
        ch3_disc_q <= `PDS_RESET_BYTE;
      end else if (ch3_disc_valid_i) begin
        ch3_disc_q <= {ch3_cls_code, ch3_det_code};
      end
      if (!ch_on_i[3] && power_enabled_flags_q[3]) begin
        ch4_disc_q <= `PDS_RESET_BYTE;
      end else if (ch4_disc_valid_i) begin
        ch4_disc_q <= {ch4_cls_code, ch4_det_code};
      end
    end
  end

  // Assigned class is reported while the channel is powered and zero otherwise.
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      ch3_assigned_o <= 3'h0;
      ch4_assigned_o <= 3'h0;
    end else begin
      ch3_assigned_o <= ch_on_i[2] ? ch3_assigned : 3'h0;
      ch4_assigned_o <= ch_on_i[3] ? ch4_assigned : 3'h0;
    end
  end

  // ---------------------------------------------------------------
  // Power-good qualification
  // ---------------------------------------------------------------
  // The raw flag latches once turn-on completes with drain below threshold; four-pair single-signature pairs gate the visible flag.
  always @* begin
    pg_raw_d  = pg_raw_q;
    pg_seen_d = pg_seen_q;
    for (i = 0; i < NCH; i = i + 1) begin
      if (!ch_on_i[i]) begin
        pg_raw_d[i]  = 1'b0;
        pg_seen_d[i] = 1'b0;
      end else begin
        if (drain_sense_pin_i[i]) begin
          pg_seen_d[i] = 1'b1;
        end
        if (turn_on_done_i[i] && (pg_seen_q[i] || drain_sense_pin_i[i])) begin
          pg_raw_d[i] = 1'b1;
        end
      end
    end
    pg_d = pg_raw_d;
    for (p = 0; p < 2; p = p + 1) begin
      if (four_pair_i[p] && !dual_sig_i[p] && !(pg_raw_d[2*p] && pg_raw_d[2*p+1])) begin
        pg_d[2*p]   = pg_raw_d[2*p] & power_good_flags_q[2*p];
        pg_d[2*p+1] = pg_raw_d[2*p+1] & power_good_flags_q[2*p+1];
      end
    end
  end

  // Power flags and change events; the power-good flags take the pair-gated pg_d.
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      pg_raw_q                    <= {NCH{1'b0}};
      pg_seen_q                   <= {NCH{1'b0}};
      power_good_flags_q          <= {NCH{1'b0}};
      power_enabled_flags_q       <= {NCH{1'b0}};
      power_good_change_event_o   <= {NCH{1'b0}};
      power_enable_change_event_o <= {NCH{1'b0}};
    end else begin
      pg_raw_q                    <= pg_raw_d;
      pg_seen_q                   <= pg_seen_d;
      power_good_flags_q          <= pg_d;
      power_enabled_flags_q       <= ch_on_i;
      power_good_change_event_o   <= power_good_flags_q & ~pg_d;
      power_enable_change_event_o <= power_enabled_flags_q & ~ch_on_i;
    end
  end

  // ---------------------------------------------------------------
  // Host read port
  // ---------------------------------------------------------------
  // Reads answer one cycle later; writes are ignored and unmapped codes read zero.
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      reg_rdata_o  <= `PDS_RESET_BYTE;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i && !reg_wr_i;
      if (reg_rd_i && !reg_wr_i) begin
        case (reg_addr_i)
          `PDS_ADDR_CH3_DISC:  reg_rdata_o <= ch3_disc_q;
          `PDS_ADDR_CH4_DISC:  reg_rdata_o <= ch4_disc_q;
          `PDS_ADDR_PWR_STATE: reg_rdata_o <= {power_good_flags_q, power_enabled_flags_q};
          default:             reg_rdata_o <= `PDS_RESET_BYTE;
        endcase
      end
    end
  end

endmodule

// ### tb/pds_chk.sv
// Checker of bank answers, status reads and channel three enable change events.
module pds_chk #(
  parameter NCH = 4
) (
  input logic           clk_i,
  input logic           resetn_i,
  input logic [NCH-1:0] ch_on_i,
  input logic           ch3_disc_valid_i,
  input logic           reg_rd_i,
  input logic           reg_wr_i,
  input logic [7:0]     reg_addr_i,
  input logic [7:0]     reg_rdata_o,
  input logic           reg_rvalid_o,
  input logic [NCH-1:0] power_enable_change_event_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // A read is taken only without a write beside it.
  wire rq = reg_rd_i && !reg_wr_i;
  // Channel three turns off while its enabled flag is set.
  sequence s_off3;
    $past(ch_on_i[2]) && !ch_on_i[2] && $past(resetn_i);
  endsequence
  sequence s_pulse3;
    power_enable_change_event_o[2] ##1 !power_enable_change_event_o[2];
  endsequence
  property p_rv; rq |=> reg_rvalid_o; endproperty
  a_rv: assert property (p_rv) else $error("read not answered");
  property p_norv; !rq |=> !reg_rvalid_o; endproperty
  a_norv: assert property (p_norv) else $error("answer without read");
  property p_unm; rq && (reg_addr_i < 8'h0E || reg_addr_i > 8'h10) |=> reg_rdata_o == 8'h00; endproperty
  a_unm: assert property (p_unm) else $error("unmapped code not zero");
  property p_pe; rq && reg_addr_i == 8'h10 && $past(resetn_i) |=> reg_rdata_o[3:0] == $past(ch_on_i[3:0], 2); endproperty
  a_pe: assert property (p_pe) else $error("enabled flags wrong");
  property p_pg; reg_rvalid_o && $past(reg_addr_i) == 8'h10 |-> (reg_rdata_o[7:4] & ~reg_rdata_o[3:0]) == 4'h0; endproperty
  a_pg: assert property (p_pg) else $error("good flag on idle channel");
  property p_evt; s_off3 |-> ##1 s_pulse3; endproperty
  a_evt: assert property (p_evt) else $error("no enable change pulse");
  property p_cause; power_enable_change_event_o[2] |-> !$past(ch_on_i[2]); endproperty
  a_cause: assert property (p_cause) else $error("stray change pulse");
  property p_clr;
    s_off3 ##2 (rq && reg_addr_i == 8'h0E && !$past(ch3_disc_valid_i) && !$past(ch3_disc_valid_i, 2))
      |=> reg_rdata_o == 8'h00;
  endproperty
  a_clr: assert property (p_clr) else $error("discovery not cleared");
endmodule
bind pds_status_bank pds_chk #(.NCH(NCH)) pds_chk_inst (.clk_i, .resetn_i, .ch_on_i, .ch3_disc_valid_i, .reg_rd_i,
  .reg_wr_i, .reg_addr_i, .reg_rdata_o, .reg_rvalid_o, .power_enable_change_event_o);

// ### tb/pds_host.sv
// Host model issuing command-code reads and writes.
module pds_host (
  input  logic       clk_i,
  input  logic [7:0] rdata_i,
  input  logic       rvalid_i,
  output logic       rd_o,
  output logic       wr_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus at time zero.
  initial {rd_o, wr_o, addr_o, wdata_o} = '0;
  // One-cycle read; a released code shows its inverse.
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    #1 {rd_o, addr_o} = {1'b1, a};
    @(posedge clk_i);
    #1 {rd_o, addr_o} = {1'b0, ~a};
    d = (rvalid_i === 1'b1) ? rdata_i : 8'hXX;
  endtask
  // One-cycle write, which the bank must ignore.
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_i);
    #1 {wr_o, addr_o, wdata_o} = {1'b1, a, v};
    @(posedge clk_i);
    #1 {wr_o, addr_o, wdata_o} = {1'b0, ~a, ~v};
  endtask
endmodule

// ### tb/testbench.sv
// Bench driving the status bank through the host model.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk_i, resetn_i, rd, wr, rvalid, v3, v4;
  logic [3:0] ch_on, drain, done, cls3, det3, cls4, det4, ev_pg, ev_pe;
  logic [1:0] fp, ds;
  logic [2:0] al3, al4, as3, as4;
  logic [7:0] addr, wdata, rdata, d;
  int         failures, comparisons;
  pds_status_bank pds_status_bank_inst (.clk_i, .resetn_i, .ch_on_i(ch_on), .drain_sense_pin_i(drain),
    .turn_on_done_i(done), .four_pair_i(fp), .dual_sig_i(ds), .ch3_cls_i(cls3), .ch3_det_i(det3),
    .ch3_disc_valid_i(v3), .ch4_cls_i(cls4), .ch4_det_i(det4), .ch4_disc_valid_i(v4), .alloc_ch3_i(al3),
    .alloc_ch4_i(al4), .reg_rd_i(rd), .reg_wr_i(wr), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .ch3_assigned_o(as3), .ch4_assigned_o(as4),
    .power_good_change_event_o(ev_pg), .power_enable_change_event_o(ev_pe));
  pds_host pds_host_inst (.clk_i, .rdata_i(rdata), .rvalid_i(rvalid), .rd_o(rd), .wr_o(wr), .addr_o(addr),
    .wdata_o(wdata));
  // Clock of 50 ns period.
  initial begin
    clk_i = 0;
    forever #25 clk_i = ~clk_i;
  end
  task tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task rdchk(input logic [7:0] a, input logic [7:0] e);
    pds_host_inst.rd(a, d);
    chk($sformatf("reg %h", a), e, d);
  endtask
  // Expected discovery byte when class and detection both carry code c.
  function automatic logic [7:0] disc(input int c);
    disc[7:4] = (c == 5) ? 4'h6 : (c == 14) ? 4'h0 : c[3:0];
    disc[3:0] = (c == 2 || c == 7 || (c > 7 && c != 14)) ? 4'h0 : c[3:0];
  endfunction
  task wrap_up;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Main sequence of tests.
  initial begin
    {resetn_i, v3, v4, ch_on, drain, done, cls3, det3, cls4, det4, fp, ds} = '0;
    {al3, al4, failures, comparisons} = {3'h1, 3'h0, 32'h0, 32'h0};
    tick(5);
    resetn_i = 1;
    for (int a = 14; a < 18; a++) rdchk(a[7:0], 8'h00);
    $display("test reset done");
    for (int c = 0; c < 16; c++) begin
      {cls3, det3, v3} = {c[3:0], c[3:0], 1'b1};
      tick(1);
      v3 = 0;
      rdchk(8'h0E, disc(c));
    end
    for (int c = 4; c < 14; c++) begin
      {cls4, det4, v4} = {c[3:0], 4'h4, 1'b1};
      tick(1);
      v4 = 0;
      if (c == 4 || c > 7) rdchk(8'h0F, 8'hC4);
    end
    $display("test discovery done");
    {cls3, cls4, v3, v4, al3, al4} = {4'h6, 4'h1, 2'b11, 3'h2, 3'h5};
    tick(1);
    {v3, v4, fp, ch_on, drain, done} = {2'b00, 2'b10, 4'h7, 4'h5, 4'h7};
    tick(3);
    chk("assigned ch3", 8'h03, {5'h00, as3});
    rdchk(8'h10, 8'h17);
    drain = 4'h0;
    rdchk(8'h10, 8'h17);
    {ch_on, drain, done} = {4'hF, 4'hC, 4'hF};
    tick(3);
    rdchk(8'h10, 8'hDF);
    chk("assigned ch4", 8'h05, {5'h00, as4});
    $display("test power done");
    ch_on = 4'hB;
    tick(1);
    chk("enable event", 8'h04, {4'h0, ev_pe});
    chk("good event", 8'h04, {4'h0, ev_pg});
    rdchk(8'h0E, 8'h00);
    rdchk(8'h10, 8'h9B);
    pds_host_inst.wr(8'h10, 8'h00);
    rdchk(8'h10, 8'h9B);
    pds_host_inst.wr(8'h0F, 8'hFF);
    rdchk(8'h0F, 8'h14);
    $display("test off and write done");
    {ds, ch_on} = {2'b10, 4'h7};
    tick(1);
    chk("dual enable event", 8'h08, {4'h0, ev_pe});
    chk("dual good event", 8'h08, {4'h0, ev_pg});
    rdchk(8'h0F, 8'h00);
    rdchk(8'h10, 8'h57);
    $display("test dual signature done");
    wrap_up;
  end
  // Watchdog against a hung bench.
  initial begin
    #100000;
    failures++;
    wrap_up;
  end
endmodule
